/* File: design/tcr_trace_control.sv */
// Trace control register with packet path, timestamps and busy status
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module tcr_trace_control
  import tcr_pkg::*;
(
  input  wire logic                      mclk_i,
  input  wire logic                      rst_n_i,
  // Register port
  input  wire logic [7:0]                reg_addr_i,
  input  wire logic [31:0]               reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic [31:0]                    reg_rdata_o,
  // Stimulus writes from the processor
  input  wire logic                      stim_valid_i,
  input  wire logic [31:0]               stim_data_i,
  output logic                           stim_ready_o,
  // Hardware events from the watchpoint unit
  input  wire logic                      hw_evt_valid_i,
  input  wire logic [31:0]               hw_evt_data_i,
  output logic                           hw_evt_ready_o,
  input  wire logic                      sync_req_i,
  // Timestamp sources
  input  wire logic [TCR_GTS_W-1:0]      gts_count_i,
  input  wire logic                      ref_tick_i,
  input  wire logic                      port_clk_i,
  input  wire logic                      line_idle_i,
  // Toward the trace port unit
  output tcr_pkg::tcr_pkt_s              pkt_o,
  output logic                           pkt_valid_o,
  input  wire logic                      pkt_ready_i,
  output logic [TCR_LSTAMP_W-1:0]        lstamp_o,
  output logic                           lstamp_tick_o,
  output logic [6:0]                     source_id_o
);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic       master_en_r;
  logic       lstamp_en_r;
  logic       sync_en_r;
  logic       hwfwd_en_r;
  logic       clksel_r;
  logic       clksel;
  logic [1:0] div_r;
  logic [1:0] grate_r;
  logic [6:0] srcid_r;
  logic       busy;
  logic       ctrl_wr;

  // Only the control offset decodes; other writes fall away
  assign ctrl_wr = reg_wr_i && (reg_addr_i == TCR_CTRL_OFFSET);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      master_en_r <= TCR_BIT_RST;
      lstamp_en_r <= TCR_BIT_RST;
      sync_en_r   <= TCR_BIT_RST;
      hwfwd_en_r  <= TCR_BIT_RST;
    end else if (ctrl_wr) begin
      master_en_r <= reg_wdata_i[TCR_MASTER_EN_BIT];
      lstamp_en_r <= reg_wdata_i[TCR_LSTAMP_EN_BIT];
      sync_en_r   <= reg_wdata_i[TCR_SYNC_EN_BIT];
      hwfwd_en_r  <= reg_wdata_i[TCR_HWFWD_EN_BIT];
    end
  end

  // Absent options keep the field at zero forever
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      grate_r <= TCR_GRATE_RST;
      div_r   <= TCR_DIV_RST;
    end else if (ctrl_wr) begin
      if (TCR_GTS_IMPL) begin
        grate_r <= reg_wdata_i[TCR_GRATE_LSB +: 2];
      end
      if (TCR_PRESC_IMPL) begin
        div_r <= reg_wdata_i[TCR_DIV_LSB +: 2];
      end
    end
  end

  // No reset: value stays undefined until software writes it
  always_ff @(posedge mclk_i) begin
    if (ctrl_wr) begin
      srcid_r <= reg_wdata_i[TCR_SRCID_LSB +: 7];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (ctrl_wr) begin
      clksel_r <= reg_wdata_i[TCR_CLKSEL_BIT];
    end
  end

  // Single-mode builds ignore the stored bit entirely
  assign clksel = (TCR_CLK_MODES == 2'h2) ? clksel_r
                                          : TCR_CLK_MODES[0];

  // No guard here; software keeps the id still while busy
  assign source_id_o = srcid_r;

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Busy is live state, so a poll sees draining end at once
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_word[TCR_BUSY_BIT] = busy;
    rd_word[TCR_SRCID_LSB +: 7] = srcid_r;
    rd_word[TCR_GRATE_LSB +: 2] = grate_r;
    rd_word[TCR_DIV_LSB +: 2] = div_r;
    rd_word[TCR_CLKSEL_BIT] = clksel;
    rd_word[TCR_HWFWD_EN_BIT] = hwfwd_en_r;
    rd_word[TCR_SYNC_EN_BIT] = sync_en_r;
    rd_word[TCR_LSTAMP_EN_BIT] = lstamp_en_r;
    rd_word[TCR_MASTER_EN_BIT] = master_en_r;
  end

  // Unmapped reads return zero; data stand for one cycle only
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i && (reg_addr_i == TCR_CTRL_OFFSET)) begin
      reg_rdata_o <= rd_word;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Global timestamp requests
  // ----------------------------------------------------------------
  logic [TCR_GTS_W-1:0] gts_prev_r;
  logic [TCR_GTS_W-1:0] gts_diff;
  logic                 gts_change;
  logic                 gts_pend_r;
  logic                 gts_take;

  // History cleared by reset; rate resets to off, so a nonzero count raises no request
  assign gts_diff = gts_count_i ^ gts_prev_r;

  always_comb begin
    case (tcr_rate_e'(grate_r))
      TCR_RATE_FINE:
        gts_change = |gts_diff[TCR_GTS_W-1:TCR_GTS_FINE_LSB];
      TCR_RATE_COARSE:
        gts_change = |gts_diff[TCR_GTS_W-1:TCR_GTS_CRSE_LSB];
      default:
        gts_change = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gts_prev_r <= '0;
    end else begin
      gts_prev_r <= gts_count_i;
    end
  end

  // New change wins over the take of an older request
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gts_pend_r <= 1'b0;
    end else if (gts_change) begin
      gts_pend_r <= 1'b1;
    end else if (gts_take || grate_r == TCR_RATE_OFF) begin
      gts_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TCR_ST_IDLE  = 3'h1,
    TCR_ST_PKT   = 3'h2,
    TCR_ST_STAMP = 3'h4
  } tcr_state_e;

  tcr_state_e state_r;
  logic       sync_pend_r;
  logic       stim_take;
  logic       hw_take;
  logic       sync_take;
  logic       idle;
  logic       stamp_due;

  assign idle           = (state_r == TCR_ST_IDLE);
  assign stim_ready_o   = idle && master_en_r;
  assign stim_take      = stim_valid_i && stim_ready_o;
  assign hw_evt_ready_o = idle && hwfwd_en_r && !stim_valid_i;
  assign hw_take        = hw_evt_valid_i && hw_evt_ready_o;
  assign sync_take      = idle && sync_pend_r && !stim_take && !hw_take;
  assign gts_take       = idle && gts_pend_r && !stim_take && !hw_take
                          && !sync_pend_r;
  assign busy           = !idle;
  assign pkt_valid_o    = !idle;

  // Only data packets earn a trailing stamp; it takes the slot just freed
  assign stamp_due      = (state_r == TCR_ST_PKT) && pkt_ready_i
                          && (grate_r == TCR_RATE_PACKET)
                          && (pkt_o.kind == TCR_PK_STIM
                              || pkt_o.kind == TCR_PK_HWEVT);

  // Sync request waits for a free slot instead of being dropped
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_pend_r <= 1'b0;
    end else if (sync_req_i && sync_en_r && master_en_r) begin
      sync_pend_r <= 1'b1;
    end else if (sync_take || !sync_en_r) begin
      sync_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= TCR_ST_IDLE;
    end else begin
      case (state_r)
        TCR_ST_IDLE: begin
          if (stim_take || hw_take || sync_take || gts_take) begin
            state_r <= TCR_ST_PKT;
          end
        end
        TCR_ST_PKT: begin
          if (stamp_due) begin
            state_r <= TCR_ST_STAMP;
          end else if (pkt_ready_i) begin
            state_r <= TCR_ST_IDLE;
          end
        end
        TCR_ST_STAMP: begin
          // Stamp waits for the port like any other packet
          if (pkt_ready_i) begin
            state_r <= TCR_ST_IDLE;
          end
        end
        default: begin
          state_r <= TCR_ST_IDLE;
        end
      endcase
    end
  end

  // Single holding slot is the output FIFO; stamp loads when it empties
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pkt_o <= '0;
    end else if (stim_take) begin
      pkt_o <= '{kind: TCR_PK_STIM, data: stim_data_i};
    end else if (hw_take) begin
      pkt_o <= '{kind: TCR_PK_HWEVT, data: hw_evt_data_i};
    end else if (sync_take) begin
      pkt_o <= '{kind: TCR_PK_SYNC, data: 32'h0000_0000};
    end else if (gts_take) begin
      pkt_o <= '{kind: TCR_PK_GSTMP, data: gts_count_i[31:0]};
    end else if (stamp_due) begin
      pkt_o <= '{kind: TCR_PK_GSTMP, data: gts_count_i[31:0]};
    end
  end

  // ----------------------------------------------------------------
  // Local timestamp counter
  // ----------------------------------------------------------------
  logic                    port_clk_d_r;
  logic                    src_tick;
  logic                    div_tick;
  logic                    lst_clear;
  logic [TCR_LSTAMP_W-1:0] lstamp_r;

  // Previous port clock level; reset matches the idle pin level
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_clk_d_r <= 1'b0;
    end else begin
      port_clk_d_r <= port_clk_i;
    end
  end

  // Port clock sampled as a level; must run below half of mclk
  assign src_tick  = clksel ? (port_clk_i && !port_clk_d_r)
                            : ref_tick_i;
  assign lst_clear = line_idle_i || !lstamp_en_r;

  tcr_stamp_prescaler u_prescaler (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .clear_i   (lst_clear),
    .tick_i    (src_tick),
    .divider_i (div_r),
    .tick_o    (div_tick)
  );

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lstamp_r <= '0;
    end else if (lst_clear) begin
      lstamp_r <= '0;
    end else if (div_tick) begin
      lstamp_r <= lstamp_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lstamp_tick_o <= 1'b0;
    end else begin
      lstamp_tick_o <= div_tick;
    end
  end

  // Counter leaves as is; its registered tick pulse rises on the same edge as the counter step
  assign lstamp_o = lstamp_r;

endmodule // tcr_trace_control

/* File: design/tcr_pkg.sv */
// Package: constants and types of the trace control register block
package tcr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  TCR_ADDR_W        = 8'h08;
  localparam logic [7:0]  TCR_CTRL_OFFSET   = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          TCR_MASTER_EN_BIT = 0;
  localparam int          TCR_LSTAMP_EN_BIT = 1;
  localparam int          TCR_SYNC_EN_BIT   = 2;
  localparam int          TCR_HWFWD_EN_BIT  = 3;
  localparam int          TCR_CLKSEL_BIT    = 4;
  localparam int          TCR_DIV_LSB       = 8;
  localparam int          TCR_GRATE_LSB     = 10;
  localparam int          TCR_SRCID_LSB     = 16;
  localparam int          TCR_BUSY_BIT      = 23;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  TCR_GRATE_RST     = 2'h0;
  localparam logic [1:0]  TCR_DIV_RST       = 2'h0;
  localparam logic        TCR_BIT_RST       = 1'h0;

  // ----------------------------------------------------------------
  // Build options
  // ----------------------------------------------------------------
  localparam logic        TCR_GTS_IMPL      = 1'h1;
  localparam logic        TCR_PRESC_IMPL    = 1'h1;
  // 2'h2: both clock modes; 2'h0: system only; 2'h1: async only
  localparam logic [1:0]  TCR_CLK_MODES     = 2'h2;

  // ----------------------------------------------------------------
  // Timestamp constants
  // ----------------------------------------------------------------
  localparam int          TCR_GTS_W         = 48;
  localparam int          TCR_GTS_FINE_LSB  = 7;
  localparam int          TCR_GTS_CRSE_LSB  = 13;
  localparam logic [5:0]  TCR_DIV1_TERM     = 6'h00;
  localparam logic [5:0]  TCR_DIV4_TERM     = 6'h03;
  localparam logic [5:0]  TCR_DIV16_TERM    = 6'h0f;
  localparam logic [5:0]  TCR_DIV64_TERM    = 6'h3f;
  localparam int          TCR_LSTAMP_W      = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TCR_RATE_OFF    = 2'h0,
    TCR_RATE_FINE   = 2'h1,
    TCR_RATE_COARSE = 2'h2,
    TCR_RATE_PACKET = 2'h3
  } tcr_rate_e;

  typedef enum logic [1:0] {
    TCR_PK_STIM  = 2'h0,
    TCR_PK_HWEVT = 2'h1,
    TCR_PK_GSTMP = 2'h2,
    TCR_PK_SYNC  = 2'h3
  } tcr_kind_e;

  typedef struct packed {
    tcr_kind_e   kind;
    logic [31:0] data;
  } tcr_pkt_s;

endpackage : tcr_pkg

/* File: design/tcr_stamp_prescaler.sv */
// Local timestamp prescaler: divides reference ticks by 1, 4, 16 or 64
`timescale 1ns/1ps
module tcr_stamp_prescaler
  import tcr_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clear_i,
  input  wire logic       tick_i,
  input  wire logic [1:0] divider_i,
  output logic            tick_o
);

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  logic [5:0] count_r;
  logic [5:0] term;

  always_comb begin
    case (divider_i)
      2'h0:    term = TCR_DIV1_TERM;
      2'h1:    term = TCR_DIV4_TERM;
      2'h2:    term = TCR_DIV16_TERM;
      default: term = TCR_DIV64_TERM;
    endcase
  end

  // Count restarts on clear so the first stamp is a full period
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= 6'h00;
    end else if (clear_i) begin
      count_r <= 6'h00;
    end else if (tick_i) begin
      count_r <= (count_r >= term) ? 6'h00 : count_r + 6'h01;
    end
  end

  assign tick_o = tick_i && !clear_i && (count_r >= term);

endmodule // tcr_stamp_prescaler

/* File: test/tcr_trace_control_monitor.sv */
// Port checker of the trace control register block
`timescale 1ns/1ps
module tcr_trace_control_monitor
  import tcr_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              rst_n_i,
  input wire logic [7:0]        reg_addr_i,
  input wire logic              reg_rd_i,
  input wire logic [31:0]       reg_rdata_o,
  input wire logic              stim_valid_i,
  input wire logic [31:0]       stim_data_i,
  input wire logic              stim_ready_o,
  input wire logic              hw_evt_valid_i,
  input wire logic [31:0]       hw_evt_data_i,
  input wire logic              hw_evt_ready_o,
  input wire logic              line_idle_i,
  input wire tcr_pkg::tcr_pkt_s pkt_o,
  input wire logic              pkt_valid_o,
  input wire logic              pkt_ready_i,
  input wire logic [15:0]       lstamp_o,
  input wire logic              lstamp_tick_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  property p_busy;
    $past(reg_rd_i && reg_addr_i == 8'h00) |->
      reg_rdata_o[23] == $past(pkt_valid_o);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy bit differs from packet state");
  property p_rsvd;
    reg_rdata_o[31:24] == 8'h00 && reg_rdata_o[15:12] == 4'h0 &&
      reg_rdata_o[7:5] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved read bits not zero");
  // Unmapped reads and idle cycles both leave read data at zero
  property p_rdzero;
    !$past(reg_rd_i && reg_addr_i == 8'h00) |-> reg_rdata_o == 32'h0;
  endproperty
  a_rdzero: assert property (p_rdzero)
    else $error("read data outside a mapped read");
  // ----------------------------------------------------------------
  // Packet path and local stamp
  // ----------------------------------------------------------------
  property p_stim;
    stim_valid_i && stim_ready_o |=> pkt_valid_o &&
      pkt_o.kind == TCR_PK_STIM && pkt_o.data == $past(stim_data_i);
  endproperty
  a_stim: assert property (p_stim)
    else $error("stimulus word not forwarded");
  property p_hw;
    hw_evt_valid_i && hw_evt_ready_o |=> pkt_valid_o &&
      pkt_o.kind == TCR_PK_HWEVT && pkt_o.data == $past(hw_evt_data_i);
  endproperty
  a_hw: assert property (p_hw)
    else $error("hardware event not forwarded");
  property p_hold;
    pkt_valid_o && !pkt_ready_i |=> pkt_valid_o && $stable(pkt_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("packet dropped before acceptance");
  property p_refuse;
    pkt_valid_o || stim_valid_i |-> !hw_evt_ready_o;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("hardware event taken while busy");
  property p_idle;
    line_idle_i [*2] |-> lstamp_o == 16'h0;
  endproperty
  a_idle: assert property (p_idle)
    else $error("stamp counter runs while line idle");
  property p_step;
    lstamp_o != 16'h0 && lstamp_o != $past(lstamp_o) |->
      lstamp_o == $past(lstamp_o) + 16'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("stamp counter jumped");
  property p_tick;
    lstamp_tick_o |-> lstamp_o == $past(lstamp_o) + 16'h1;
  endproperty
  a_tick: assert property (p_tick)
    else $error("stamp tick without counter step");
  c_stim: cover property (stim_valid_i && stim_ready_o);
  c_hw: cover property (hw_evt_valid_i && hw_evt_ready_o);
  c_gst: cover property (pkt_valid_o && pkt_o.kind == TCR_PK_GSTMP);
  c_tick: cover property (lstamp_tick_o);
endmodule // tcr_trace_control_monitor

bind tcr_trace_control tcr_trace_control_monitor tcr_trace_control_monitor_i (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .stim_valid_i(stim_valid_i), .stim_data_i(stim_data_i),
  .stim_ready_o(stim_ready_o), .hw_evt_valid_i(hw_evt_valid_i),
  .hw_evt_data_i(hw_evt_data_i), .hw_evt_ready_o(hw_evt_ready_o),
  .line_idle_i(line_idle_i), .pkt_o(pkt_o), .pkt_valid_o(pkt_valid_o),
  .pkt_ready_i(pkt_ready_i), .lstamp_o(lstamp_o),
  .lstamp_tick_o(lstamp_tick_o));

/* File: test/tcr_port_model.sv */
// Model of the trace port unit that takes packets
`timescale 1ns/1ps
module tcr_port_model
  import tcr_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire tcr_pkg::tcr_pkt_s pkt_i,
  input  wire logic              pkt_valid_i,
  input  wire logic [1:0]        mode_i,
  output logic                   pkt_ready_o
);
  tcr_pkt_s   rx_q[$];
  logic [7:0] lfsr_r;
  // Mode 0 always takes, 1 stalls at random, 2 never takes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr_r      <= 8'h5a;
      pkt_ready_o <= 1'b0;
    end else begin
      lfsr_r      <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[3]};
      pkt_ready_o <= mode_i == 2'h0 || (mode_i == 2'h1 && lfsr_r[0]);
    end
  end
  always @(posedge mclk_i) begin
    if (rst_n_i && pkt_valid_i && pkt_ready_o) begin
      rx_q.push_back(pkt_i);
    end
  end
endmodule // tcr_port_model

/* File: test/trace_control_register_tb.sv */
// Self-checking bench of the trace control register block
`timescale 1ns/1ps
module trace_control_register_tb;
  import tcr_pkg::*;
  logic        mclk_i, rst_n_i, reg_wr_i, reg_rd_i, stim_valid_i;
  logic        hw_evt_valid_i, sync_req_i, ref_tick_i, port_clk_i;
  logic        line_idle_i, pkt_valid_o, pkt_ready_i, ok;
  logic        stim_ready_o, hw_evt_ready_o, lstamp_tick_o;
  logic [1:0]  mode;
  logic [7:0]  reg_addr_i;
  logic [6:0]  source_id_o;
  logic [15:0] lstamp_o;
  logic [47:0] gts_count_i, g;
  logic [31:0] reg_wdata_i, reg_rdata_o, stim_data_i, hw_evt_data_i;
  logic [31:0] v, d, rng, exp_k[$], exp_d[$];
  tcr_pkt_s    pkt_o, p;
  int          n_mismatch, compares, n_cyc;
  int          rt[6] = '{1, 1, 2, 2, 0, 1};
  int          bt[6] = '{6, 7, 12, 13, 13, 47};
  tcr_trace_control tcr_trace_control_i (.mclk_i(mclk_i),
    .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .stim_valid_i(stim_valid_i), .stim_data_i(stim_data_i),
    .stim_ready_o(stim_ready_o), .hw_evt_valid_i(hw_evt_valid_i),
    .hw_evt_data_i(hw_evt_data_i), .hw_evt_ready_o(hw_evt_ready_o),
    .sync_req_i(sync_req_i), .gts_count_i(gts_count_i),
    .ref_tick_i(ref_tick_i), .port_clk_i(port_clk_i),
    .line_idle_i(line_idle_i), .pkt_o(pkt_o), .pkt_valid_o(pkt_valid_o),
    .pkt_ready_i(pkt_ready_i), .lstamp_o(lstamp_o),
    .lstamp_tick_o(lstamp_tick_o), .source_id_o(source_id_o));
  tcr_port_model tcr_port_model_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .pkt_i(pkt_o), .pkt_valid_i(pkt_valid_o), .mode_i(mode),
    .pkt_ready_o(pkt_ready_i));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge mclk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= w;
    reg_wr_i    <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i   <= 1'b0;
    #1 r = reg_rdata_o;
  endtask
  // Holds the word until taken; gives up after 40 cycles
  task automatic offer(input logic hw, input logic [31:0] w);
    ok = 1'b0;
    @(posedge mclk_i);
    stim_valid_i   <= !hw;
    hw_evt_valid_i <= hw;
    stim_data_i    <= w;
    hw_evt_data_i  <= w;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge mclk_i);
      ok = (hw ? hw_evt_ready_o : stim_ready_o) === 1'b1;
      @(posedge mclk_i);
    end
    stim_valid_i   <= 1'b0;
    hw_evt_valid_i <= 1'b0;
    if (ok) begin
      exp_k.push_back({31'h0, hw});
      exp_d.push_back(w);
    end
  endtask
  task automatic check_rx();
    chk(tcr_port_model_i.rx_q.size(), exp_k.size());
    while (exp_k.size() > 0 && tcr_port_model_i.rx_q.size() > 0) begin
      p = tcr_port_model_i.rx_q.pop_front();
      chk(32'(p.kind), exp_k[0]);
      if (exp_k.pop_front() != 3) chk(p.data, exp_d[0]);
      void'(exp_d.pop_front());
    end
    exp_k.delete();
    exp_d.delete();
    tcr_port_model_i.rx_q.delete();
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    n_cyc++;
    if (n_cyc == 10000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, stim_valid_i, hw_evt_valid_i} = '0;
    {sync_req_i, ref_tick_i, port_clk_i, line_idle_i, mode} = '0;
    {reg_addr_i, reg_wdata_i, stim_data_i, hw_evt_data_i} = '0;
    rng = 32'd24909;
    gts_count_i = {xs(), xs()};
    cyc(12);
    rst_n_i <= 1'b1;
    cyc(2);
    rd(8'h00, v);
    chk(v & 32'hff80_ffef, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = xs();
      wr(8'h00, d);
      wr(8'h04, ~d);
      rd(8'h00, v);
      chk(v, d & 32'h007f_0f1f);
      rd(8'h04, v);
      chk(v, 32'h0);
    end
    $display("done: registers");
    wr(8'h00, 32'h1);
    mode <= 2'h2;
    offer(1'b0, xs());
    rd(8'h00, v);
    chk(32'(v[23]), 32'h1);
    mode <= 2'h1;
    for (int i = 0; i < 6; i++) offer(1'b0, xs());
    mode <= 2'h0;
    cyc(10);
    check_rx();
    rd(8'h00, v);
    chk(32'(v[23]), 32'h0);
    wr(8'h00, 32'h0);
    offer(1'b0, xs());
    chk(32'(ok), 32'h0);
    offer(1'b1, xs());
    chk(32'(ok), 32'h0);
    wr(8'h00, 32'h8);
    offer(1'b1, xs());
    cyc(5);
    check_rx();
    wr(8'h00, 32'h0);
    rd(8'h00, v);
    for (int i = 0; i < 20 && v[23]; i++) rd(8'h00, v);
    chk(32'(v[23]), 32'h0);
    d = xs();
    wr(8'h00, {9'h0, d[6:0] | 7'h01, 16'h0});
    cyc(1);
    chk(32'(source_id_o), 32'(d[6:0] | 7'h01));
    $display("done: packets");
    for (int s = 0; s < 2; s++) begin
      wr(8'h00, 32'h1 | (s << 2));
      if (s == 1) exp_k.push_back(32'h3);
      if (s == 1) exp_d.push_back(32'h0);
      sync_req_i <= 1'b1;
      cyc(1);
      sync_req_i <= 1'b0;
      cyc(6);
      check_rx();
    end
    wr(8'h00, 32'h0c01);
    offer(1'b0, xs());
    exp_k.push_back(32'h2);
    exp_d.push_back(gts_count_i[31:0]);
    cyc(8);
    check_rx();
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, 32'h1 | (rt[i] << 10));
      cyc(4);
      tcr_port_model_i.rx_q.delete();
      g = gts_count_i ^ (48'h1 << bt[i]);
      gts_count_i <= g;
      if ((rt[i] == 1 && bt[i] >= 7) || (rt[i] == 2 && bt[i] >= 13)) begin
        exp_k.push_back(32'h2);
        exp_d.push_back(g[31:0]);
      end
      cyc(8);
      check_rx();
    end
    $display("done: global stamps");
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h0);
      wr(8'h00, 32'h2 | (i << 8));
      repeat (64) begin
        ref_tick_i <= 1'b1;
        cyc(1);
        ref_tick_i <= 1'b0;
        cyc(1);
      end
      cyc(3);
      chk(32'(lstamp_o), 64 >> (2 * i));
    end
    line_idle_i <= 1'b1;
    cyc(3);
    chk(32'(lstamp_o), 32'h0);
    line_idle_i <= 1'b0;
    // Reference ticks run too; only port clock edges may count
    wr(8'h00, 32'h12);
    repeat (8) begin
      port_clk_i <= 1'b1;
      ref_tick_i <= 1'b1;
      cyc(1);
      ref_tick_i <= 1'b0;
      cyc(2);
      port_clk_i <= 1'b0;
      cyc(3);
    end
    cyc(3);
    chk(32'(lstamp_o), 32'h8);
    $display("done: local stamps");
    final_report();
  end
endmodule // trace_control_register_tb
